// ---- hw/post_clear_pkg.sv ----
// package: register map, bit layout and reset values of the posted flag block
package post_clear_pkg;

    // ========================================================================
    // register indices as printed, byte address is four times the index
    // ========================================================================
    localparam logic [7:0] IDX_CLEAR_LOW  = 8'hDB;
    localparam logic [7:0] IDX_CLEAR_HIGH = 8'hDC;
    localparam logic [7:0] IDX_POST_CTRL  = 8'hE1;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'hE2;
    localparam logic [7:0] IDX_IRQ_MASK   = 8'hE3;

    localparam int WB_ADDR_W = 10;
    localparam logic [1:0] WB_WORD_LSB = 2'h0;

    // ========================================================================
    // widths and layout
    // ========================================================================
    localparam int REG_W      = 8;
    localparam int LOW_W      = 8;
    localparam int HIGH_W     = 6;
    localparam int NUM_SRC    = LOW_W + HIGH_W;

    // low register bits
    localparam int BIT_COUNTER_ONE = 0;
    localparam int BIT_COUNTER_TWO = 1;
    localparam int BIT_BUS_RESET   = 2;
    localparam int BIT_FRAME_START = 3;
    localparam int BIT_EP_CHANNEL_0 = 4;
    localparam int BIT_EP_CHANNEL_3 = 7;
    // high register bits
    localparam int BIT_EP_CHANNEL_4 = 0;
    localparam int BIT_EP_CHANNEL_8 = 4;
    localparam int BIT_BUS_WAKEUP   = 5;

    // control register bit
    localparam int BIT_SW_POST_EN = 0;

    // event status bits
    localparam int EVT_W        = 2;
    localparam int EVT_LOW_ANY  = 0;
    localparam int EVT_HIGH_ANY = 1;

    localparam logic [LOW_W-1:0]  RESET_LOW  = 8'h00;
    localparam logic [HIGH_W-1:0] RESET_HIGH = 6'h00;
    localparam logic [EVT_W-1:0]  RESET_EVT  = 2'h0;

endpackage : post_clear_pkg

// ---- hw/posted_flag_cell.sv ----
// module: one posted interrupt flag with hardware set and software write
`timescale 1ns/1ps
`default_nettype none

module posted_flag_cell
(
    input  wire logic clk_i,      // system clock
    input  wire logic rst_i,      // synchronous reset, active high
    input  wire logic hw_set_i,   // source raised its interrupt
    input  wire logic wr_i,       // register write this cycle
    input  wire logic wr_bit_i,   // written value of this bit
    input  wire logic sw_en_i,    // software post enable
    output var  logic flag_o      // posted state
);

    logic flag_q;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            flag_q <= 1'b0;
        else if (hw_set_i)
            flag_q <= 1'b1;
        else if (wr_i && sw_en_i && wr_bit_i)
            flag_q <= 1'b1;
        else if (wr_i && !sw_en_i && !wr_bit_i)
            flag_q <= 1'b0;
        // write 1 with enable clear, write 0 with enable set: hold
    end

    assign flag_o = flag_q;

endmodule : posted_flag_cell

`default_nettype wire

// ---- hw/interrupt_post_clear_regs.sv ----
// module: posted flag clear registers with wishbone slave and interrupt out
`timescale 1ns/1ps
`default_nettype none

// Function
// - read returns one per posted source
// - write zero, enable clear: clear posted flag
// - write one, enable clear: no change
// - write zero, enable set: no change
// - write one, enable set: post interrupt
// - low register: endpoints 3-0, frame, reset, counters
// - high register: wakeup bit 5, endpoints 8-4
// - mask blocks pending only, never posting
module interrupt_post_clear_regs
    import post_clear_pkg::*;
(
    input  wire logic                 clk_i,        // system clock 40 MHz
    input  wire logic                 rst_i,        // sync reset, active high
    input  wire logic                 wb_cyc_i,     // wishbone cycle
    input  wire logic                 wb_stb_i,     // wishbone strobe
    input  wire logic                 wb_we_i,      // wishbone write enable
    input  wire logic [WB_ADDR_W-1:0] wb_adr_i,     // wishbone byte address
    input  wire logic [3:0]           wb_sel_i,     // wishbone byte selects
    input  wire logic [31:0]          wb_dat_i,     // wishbone write data
    output var  logic [31:0]          wb_dat_o,     // wishbone read data
    output var  logic                 wb_ack_o,     // wishbone acknowledge
    input  wire logic                 counter_one_source_i, // counter one
    input  wire logic                 counter_two_source_i, // counter two
    input  wire logic                 bus_reset_src_i,      // bus reset
    input  wire logic                 frame_start_src_i,    // start of frame
    input  wire logic [3:0]           ep_low_src_i,         // endpoints 3..0
    input  wire logic [4:0]           ep_high_src_i,        // endpoints 8..4
    input  wire logic                 bus_wakeup_src_i,     // bus wakeup
    input  wire logic [NUM_SRC-1:0]   src_unmask_i,         // mask regs, 1=on
    output var  logic [NUM_SRC-1:0]   pending_o,    // posted and unmasked
    output var  logic                 irq_o         // block interrupt level
);

    // ========================================================================
    // source edge detect, sources come from logic on clk_i, no sync
    // ========================================================================
    logic [NUM_SRC-1:0] src_raw;
    logic [NUM_SRC-1:0] src_prev_q;
    logic [NUM_SRC-1:0] src_rise;

    always_comb
    begin
        src_raw = '0;
        src_raw[BIT_COUNTER_ONE] = counter_one_source_i;
        src_raw[BIT_COUNTER_TWO] = counter_two_source_i;
        src_raw[BIT_BUS_RESET]   = bus_reset_src_i;
        src_raw[BIT_FRAME_START] = frame_start_src_i;
        src_raw[BIT_EP_CHANNEL_3:BIT_EP_CHANNEL_0] = ep_low_src_i;
        src_raw[LOW_W+BIT_EP_CHANNEL_8:LOW_W+BIT_EP_CHANNEL_4] =
            ep_high_src_i;
        src_raw[LOW_W+BIT_BUS_WAKEUP] = bus_wakeup_src_i;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            src_prev_q <= '0;
        else
            src_prev_q <= src_raw;
    end

    assign src_rise = src_raw & ~src_prev_q;

    // ========================================================================
    // wishbone decode
    // ========================================================================
    logic [7:0] word_idx;
    logic       req;
    logic       wr_low;
    logic       wr_high;
    logic       wr_ctrl;
    logic       wr_stat;
    logic       wr_mask;
    logic       ack_q;

    assign word_idx = wb_adr_i[WB_ADDR_W-1:2];
    assign req      = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr_low   = req && wb_we_i && wb_sel_i[0] &&
                      word_idx == IDX_CLEAR_LOW;
    assign wr_high  = req && wb_we_i && wb_sel_i[0] &&
                      word_idx == IDX_CLEAR_HIGH;
    assign wr_ctrl  = req && wb_we_i && wb_sel_i[0] &&
                      word_idx == IDX_POST_CTRL;
    assign wr_stat  = req && wb_we_i && wb_sel_i[0] &&
                      word_idx == IDX_IRQ_STATUS;
    assign wr_mask  = req && wb_we_i && wb_sel_i[0] &&
                      word_idx == IDX_IRQ_MASK;

    // ========================================================================
    // software post enable control register
    // ========================================================================
    logic sw_post_en_q;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            sw_post_en_q <= 1'b0;
        else if (wr_ctrl)
            sw_post_en_q <= wb_dat_i[BIT_SW_POST_EN];
    end

    // ========================================================================
    // posted flags, one cell per source
    // ========================================================================
    logic [NUM_SRC-1:0] posted;
    logic [NUM_SRC-1:0] wr_vec;
    logic [NUM_SRC-1:0] wr_data;

    assign wr_vec  = {{HIGH_W{wr_high}}, {LOW_W{wr_low}}};
    // reserved high bits are dropped, software keeps them zero
    assign wr_data = {wb_dat_i[HIGH_W-1:0], wb_dat_i[LOW_W-1:0]};

    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++)
        begin : gen_flag
            posted_flag_cell u_cell
            (
                .clk_i    (clk_i),
                .rst_i    (rst_i),
                .hw_set_i (src_rise[g]),
                .wr_i     (wr_vec[g]),
                .wr_bit_i (wr_data[g]),
                .sw_en_i  (sw_post_en_q),
                .flag_o   (posted[g])
            );
        end
    endgenerate

    // ========================================================================
    // pending vector, mask gates pending only
    // ========================================================================
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            pending_o <= '0;
        else
            pending_o <= posted & src_unmask_i;
    end

    // ========================================================================
    // block events: sticky status, write one to clear, mask, irq
    // ========================================================================
    logic [EVT_W-1:0] evt_set;
    logic [EVT_W-1:0] evt_status_q;
    logic [EVT_W-1:0] evt_mask_q;

    always_comb
    begin
        evt_set = '0;
        evt_set[EVT_LOW_ANY]  = |src_rise[LOW_W-1:0];
        evt_set[EVT_HIGH_ANY] = |src_rise[NUM_SRC-1:LOW_W];
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            evt_status_q <= RESET_EVT;
        else if (wr_stat)
            evt_status_q <= (evt_status_q & ~wb_dat_i[EVT_W-1:0]) | evt_set;
        else
            evt_status_q <= evt_status_q | evt_set;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            evt_mask_q <= RESET_EVT;
        else if (wr_mask)
            evt_mask_q <= wb_dat_i[EVT_W-1:0];
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irq_o <= 1'b0;
        else
            irq_o <= |(evt_status_q & evt_mask_q);
    end

    // ========================================================================
    // read mux and acknowledge
    // ========================================================================
    logic [REG_W-1:0] rd_byte;

    always_comb
    begin
        case (word_idx)
            IDX_CLEAR_LOW:  rd_byte = posted[LOW_W-1:0];
            IDX_CLEAR_HIGH: rd_byte = {2'h0, posted[NUM_SRC-1:LOW_W]};
            IDX_POST_CTRL:  rd_byte = {7'h00, sw_post_en_q};
            IDX_IRQ_STATUS: rd_byte = {6'h00, evt_status_q};
            IDX_IRQ_MASK:   rd_byte = {6'h00, evt_mask_q};
            default:        rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q    <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            ack_q <= req;
            if (req && !wb_we_i)
                wb_dat_o <= {24'h00_0000, rd_byte};
        end
    end

    assign wb_ack_o = ack_q;

endmodule : interrupt_post_clear_regs

`default_nettype wire

// ---- verif/post_clear_checker.sv ----
// checker: port-level properties of the posted flag registers
`timescale 1ns/1ps
`default_nettype none
module post_clear_checker
    import post_clear_pkg::*;
(
    input  wire logic                 clk_i,                // clock
    input  wire logic                 rst_i,                // reset
    input  wire logic                 wb_cyc_i,             // cycle
    input  wire logic                 wb_stb_i,             // strobe
    input  wire logic                 wb_we_i,              // write
    input  wire logic [WB_ADDR_W-1:0] wb_adr_i,             // address
    input  wire logic [3:0]           wb_sel_i,             // byte selects
    input  wire logic [31:0]          wb_dat_i,             // write data
    input  wire logic [31:0]          wb_dat_o,             // read data
    input  wire logic                 wb_ack_o,             // acknowledge
    input  wire logic                 counter_one_source_i, // source 0
    input  wire logic [NUM_SRC-1:0]   src_unmask_i,         // unmask
    input  wire logic [NUM_SRC-1:0]   pending_o,            // pending
    input  wire logic                 irq_o                 // interrupt
);
    logic en_q;
    logic tk;
    logic wlo;
    assign tk = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wlo = tk && wb_we_i && wb_sel_i[0] &&
                 wb_adr_i[9:2] == IDX_CLEAR_LOW;
    // shadow of the software post enable
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            en_q <= 1'b0;
        else if (tk && wb_we_i && wb_sel_i[0] &&
                 wb_adr_i[9:2] == IDX_POST_CTRL)
            en_q <= wb_dat_i[0];
    end
    // ========================================================================
    // assertions
    // ========================================================================
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_answer: assert property (tk |=> wb_ack_o)
        else $error("request not acknowledged");
    a_read_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_high_reserved: assert property (wb_ack_o && !wb_we_i
        && wb_adr_i[9:2] == IDX_CLEAR_HIGH |-> wb_dat_o[7:6] == 2'h0)
        else $error("reserved bits read as one");
    a_pend_masked: assert property
        ((pending_o & ~$past(src_unmask_i)) == '0)
        else $error("masked source pending");
    a_hw_post: assert property
        ($rose(counter_one_source_i) && src_unmask_i[0]
         |-> ##[1:3] pending_o[0])
        else $error("source rise not posted");
    a_sw_clear: assert property
        (wlo && !en_q && !wb_dat_i[0] && !counter_one_source_i
         |-> ##2 !pending_o[0])
        else $error("write zero did not clear");
    a_sw_post: assert property
        (wlo && en_q && wb_dat_i[0] && src_unmask_i[0] |-> ##2 pending_o[0])
        else $error("write one did not post");
    a_reset_quiet: assert property (disable iff (1'b0)
        rst_i |=> !wb_ack_o && pending_o == '0 && !irq_o)
        else $error("outputs active after reset");
    cover property (wlo && en_q);
    cover property ($rose(irq_o));
    cover property (wb_ack_o && wb_adr_i[9:2] == IDX_CLEAR_HIGH);
endmodule : post_clear_checker
`default_nettype wire

// ---- verif/src_model.sv ----
// model: hardware interrupt sources in posted flag layout
`timescale 1ns/1ps
`default_nettype none
module src_model
    import post_clear_pkg::*;
(
    input  wire logic               clk_i, // clock
    output var  logic [NUM_SRC-1:0] src_o  // source levels
);
    initial src_o = '0;
    // two-cycle level pulse; the rise is the event
    task automatic raise(input int k);
        @(posedge clk_i);
        src_o[k] <= 1'b1;
        repeat (2) @(posedge clk_i);
        src_o[k] <= 1'b0;
        @(posedge clk_i);
    endtask : raise
endmodule : src_model
`default_nettype wire

// ---- verif/tb_interrupt_post_clear_regs.sv ----
// testbench: posted flag clear registers over wishbone
`timescale 1ns/1ps
`default_nettype none
module tb_interrupt_post_clear_regs
    import post_clear_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, irq;
    logic [9:0] adr = '0;
    logic [3:0] sel = 4'hF;
    logic [31:0] wdat = '0, rdat, rv;
    logic [13:0] src, pend, f = '0;
    logic [13:0] unmask = 14'h3FFF;
    int bad_count = 0, num_checks = 0, cycles = 0;
    always #12.5 clk_i = ~clk_i;
    interrupt_post_clear_regs interrupt_post_clear_regs_i (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .counter_one_source_i(src[0]),
        .counter_two_source_i(src[1]), .bus_reset_src_i(src[2]),
        .frame_start_src_i(src[3]), .ep_low_src_i(src[7:4]),
        .ep_high_src_i(src[12:8]), .bus_wakeup_src_i(src[13]),
        .src_unmask_i(unmask), .pending_o(pend), .irq_o(irq));
    src_model src_model_i (.clk_i(clk_i), .src_o(src));
    task wb(input logic w, input logic [7:0] i, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {i, WB_WORD_LSB};
        wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        rv = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h exp %h", $time, g, e);
        end
    endtask : chk
    task rd(input logic [7:0] i, input logic [31:0] e);
        wb(1'b0, i, 32'h0);
        chk(rv, e);
    endtask : rd
    task results();
        if (bad_count == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : results
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            bad_count++;
            results();
        end
    end
    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(IDX_CLEAR_LOW, 32'h0);
        rd(IDX_CLEAR_HIGH, 32'h0);
        for (int k = 0; k < NUM_SRC; k++)
        begin
            src_model_i.raise(k);
            f[k] = 1'b1;
            rd(IDX_CLEAR_LOW, {24'h0, f[7:0]});
            rd(IDX_CLEAR_HIGH, {26'h0, f[13:8]});
        end
        rd(IDX_IRQ_STATUS, 32'h3);
        chk({31'h0, irq}, 32'h0);
        wb(1'b1, IDX_IRQ_MASK, 32'h3);
        rd(IDX_IRQ_STATUS, 32'h3);
        chk({31'h0, irq}, 32'h1);
        wb(1'b1, IDX_IRQ_STATUS, 32'h1);
        rd(IDX_IRQ_STATUS, 32'h2);
        chk({31'h0, irq}, 32'h1);
        wb(1'b1, IDX_IRQ_STATUS, 32'h2);
        rd(IDX_IRQ_STATUS, 32'h0);
        chk({31'h0, irq}, 32'h0);
        wb(1'b1, IDX_CLEAR_LOW, 32'hF0);
        rd(IDX_CLEAR_LOW, 32'hF0);
        wb(1'b1, IDX_CLEAR_HIGH, 32'h00);
        rd(IDX_CLEAR_HIGH, 32'h00);
        wb(1'b1, IDX_CLEAR_LOW, 32'h00);
        rd(IDX_CLEAR_LOW, 32'h00);
        wb(1'b1, IDX_POST_CTRL, 32'h1);
        rd(IDX_POST_CTRL, 32'h1);
        wb(1'b1, IDX_CLEAR_LOW, 32'hA5);
        rd(IDX_CLEAR_LOW, 32'hA5);
        wb(1'b1, IDX_CLEAR_LOW, 32'h00);
        rd(IDX_CLEAR_LOW, 32'hA5);
        sel <= 4'hE;
        wb(1'b1, IDX_CLEAR_LOW, 32'hFF);
        sel <= 4'hF;
        rd(IDX_CLEAR_LOW, 32'hA5);
        wb(1'b1, IDX_CLEAR_HIGH, 32'h21);
        rd(IDX_CLEAR_HIGH, 32'h21);
        unmask <= 14'h0F0F;
        rd(IDX_CLEAR_LOW, 32'hA5);
        chk({18'h0, pend}, 32'h0105);
        src_model_i.raise(6);
        rd(IDX_CLEAR_LOW, 32'hE5);
        chk({18'h0, pend}, 32'h0105);
        wb(1'b1, 8'h10, 32'hFF);
        rd(8'h10, 32'h0);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(IDX_CLEAR_LOW, 32'h0);
        rd(IDX_CLEAR_HIGH, 32'h0);
        rd(IDX_POST_CTRL, 32'h0);
        chk({18'h0, pend}, 32'h0);
        chk({31'h0, irq}, 32'h0);
        results();
    end
endmodule : tb_interrupt_post_clear_regs
bind interrupt_post_clear_regs post_clear_checker post_clear_checker_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .counter_one_source_i(counter_one_source_i),
    .src_unmask_i(src_unmask_i), .pending_o(pending_o), .irq_o(irq_o));
`default_nettype wire
